// ==== dv/corr_far_model.sv ====
// Purpose: Far side receiver of the four request lines
// Assumes: Request inputs already turned active high
// Notes: Sticky record, cleared by the bench between pulses
`timescale 1ns/1ps
module corr_far_model (
  input wire clk_in,
  input wire clr_in,
  input wire [3:0] req_in,
  output reg [3:0] seen_out
);
  // Sticky so a one-cycle request is never missed
  always @(posedge clk_in) begin
    if (clr_in) begin
      seen_out <= 4'h0;
    end else begin
      seen_out <= seen_out | req_in;
    end
  end
endmodule

// ==== dv/corr_monitor.sv ====
// Purpose: Port checker for corr_top
// Assumes: One clock, asynchronous active-low reset
// Notes: Bound to every corr_top instance
`timescale 1ns/1ps
`include "corr_defs.vh"
module corr_monitor (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire CP_RD_IN,
  input wire CP_WR_IN,
  input wire [3:0] CP_CRN_IN,
  input wire [3:0] CP_CRM_IN,
  input wire [2:0] CP_OPC2_IN,
  input wire [31:0] CP_WDATA_IN,
  input wire CP_PRIV_IN,
  input wire MONITOR_USER_ACCESS_ENABLE_IN,
  input wire CYCLE_COUNTER_OVF_IN,
  input wire [2:0] EVENT_COUNTER_OVF_IN,
  input wire [31:0] CP_RDATA_OUT,
  input wire CP_UNDEF_OUT,
  input wire OVERFLOW_INTERRUPT_REQUEST_N_OUT,
  input wire OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT,
  input wire OVERFLOW_RESET_REQUEST_N_OUT,
  input wire OVERFLOW_DEBUG_REQUEST_OUT,
  input wire [3:0] CACHE_DSIZE_OUT
);
  ////////////////////////////////////////////////////////////////
  // Decoded access kinds
  wire acc = CP_RD_IN | CP_WR_IN;
  wire grp = acc && CP_CRN_IN == `CORR_CRN_VAL;
  wire en_sel = grp && CP_CRM_IN == `CORR_CRM_EN;
  wire ov_sel = grp && CP_CRM_IN == `CORR_CRM_CSO && CP_OPC2_IN == `CORR_OP2_CSO;
  wire ovf = CYCLE_COUNTER_OVF_IN | (|EVENT_COUNTER_OVF_IN);
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RST_N_IN);
  sequence s_rd_ref;
    CP_RD_IN && CP_UNDEF_OUT;
  endsequence
  sequence s_cso_wr;
    CP_WR_IN && ov_sel && CP_PRIV_IN
      && CP_WDATA_IN[7:4] inside {[`CORR_SIZE_4K:`CORR_SIZE_64K]};
  endsequence
  property p_irq; !OVERFLOW_INTERRUPT_REQUEST_N_OUT |-> $past(ovf); endproperty
  property p_fiq; !OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT |-> $past(ovf); endproperty
  property p_rst; !OVERFLOW_RESET_REQUEST_N_OUT |-> $past(ovf); endproperty
  property p_dbg; OVERFLOW_DEBUG_REQUEST_OUT |-> $past(ovf); endproperty
  property p_user; en_sel && !CP_PRIV_IN && !MONITOR_USER_ACCESS_ENABLE_IN |-> CP_UNDEF_OUT;
  endproperty
  property p_priv; en_sel && CP_PRIV_IN |-> !CP_UNDEF_OUT; endproperty
  property p_ovrd; CP_RD_IN && ov_sel |-> CP_UNDEF_OUT; endproperty
  property p_ref; s_rd_ref |=> CP_RDATA_OUT == 32'h0; endproperty
  property p_cso; s_cso_wr |=> CACHE_DSIZE_OUT == $past(CP_WDATA_IN[7:4]); endproperty
  property p_rsvd; CP_RDATA_OUT[30:3] == 28'h0; endproperty
  a_irq: assert property (p_irq) else $error("irq request without overflow");
  a_fiq: assert property (p_fiq) else $error("fiq request without overflow");
  a_rst: assert property (p_rst) else $error("reset request without overflow");
  a_dbg: assert property (p_dbg) else $error("debug request without overflow");
  a_user: assert property (p_user) else $error("user access not refused");
  a_priv: assert property (p_priv) else $error("privileged access refused");
  a_ovrd: assert property (p_ovrd) else $error("override read not refused");
  a_ref: assert property (p_ref) else $error("refused read data not zero");
  a_cso: assert property (p_cso) else $error("data size not replaced");
  a_rsvd: assert property (p_rsvd) else $error("reserved bits not zero");
endmodule
bind corr_top corr_monitor u_corr_monitor (.REF_CLK_IN, .RST_N_IN, .CP_RD_IN, .CP_WR_IN,
  .CP_CRN_IN, .CP_CRM_IN, .CP_OPC2_IN, .CP_WDATA_IN, .CP_PRIV_IN,
  .MONITOR_USER_ACCESS_ENABLE_IN, .CYCLE_COUNTER_OVF_IN, .EVENT_COUNTER_OVF_IN,
  .CP_RDATA_OUT, .CP_UNDEF_OUT, .OVERFLOW_INTERRUPT_REQUEST_N_OUT,
  .OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT, .OVERFLOW_RESET_REQUEST_N_OUT,
  .OVERFLOW_DEBUG_REQUEST_OUT, .CACHE_DSIZE_OUT);

// ==== dv/counter_overflow_request_routing_tb_top.sv ====
// Purpose: Self-checking bench for corr_top
// Assumes: Inputs change on the falling edge
// Notes: Enable bits {31,2,1,0} map to overflow vector {3,2,1,0}
`timescale 1ns/1ps
`include "corr_defs.vh"
module counter_overflow_request_routing_tb_top;
  localparam [7:0] eg = {`CORR_CRN_VAL, `CORR_CRM_EN};
  localparam [10:0] cso = {`CORR_CRN_VAL, `CORR_CRM_CSO, `CORR_OP2_CSO};
  reg clk, rst_n, rd, wr, priv, mue, clr;
  reg [3:0] crn, crm, ovf, dimp, iimp;
  reg [2:0] op2;
  reg [31:0] wdata;
  wire [31:0] rdata;
  wire undef, irq_n, fiq_n, rq_n, dbg;
  wire [3:0] dsz, isz, seen;
  integer err_count, tests_run, k, i;
  corr_top DUT (.REF_CLK_IN(clk), .RST_N_IN(rst_n), .CP_RD_IN(rd), .CP_WR_IN(wr),
    .CP_CRN_IN(crn), .CP_CRM_IN(crm), .CP_OPC2_IN(op2), .CP_WDATA_IN(wdata),
    .CP_PRIV_IN(priv), .MONITOR_USER_ACCESS_ENABLE_IN(mue),
    .CYCLE_COUNTER_OVF_IN(ovf[3]), .EVENT_COUNTER_OVF_IN(ovf[2:0]),
    .IMPL_DSIZE_IN(dimp), .IMPL_ISIZE_IN(iimp), .CP_RDATA_OUT(rdata),
    .CP_UNDEF_OUT(undef), .OVERFLOW_INTERRUPT_REQUEST_N_OUT(irq_n),
    .OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT(fiq_n), .OVERFLOW_RESET_REQUEST_N_OUT(rq_n),
    .OVERFLOW_DEBUG_REQUEST_OUT(dbg), .CACHE_DSIZE_OUT(dsz), .CACHE_ISIZE_OUT(isz));
  corr_far_model u_far (.clk_in(clk), .clr_in(clr), .req_in({dbg, ~rq_n, ~fiq_n, ~irq_n}),
    .seen_out(seen));
  initial begin
    clk = 0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////
  task tally_and_finish;
    $display("errors %0d checks %0d", err_count, tests_run);
    if (err_count == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task chk1(input got, input exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t flag mismatch", $time);
    end
  endtask
  task chk32(input [31:0] got, input [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      err_count = err_count + 1;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // One register access; refusal flag is looked at inside the strobe cycle
  task cp(input w, input p, input [10:0] s, input [31:0] d, input u);
    @(negedge clk);
    rd = !w; wr = w; {crn, crm, op2} = s; wdata = d; priv = p;
    #1 chk1(undef, u);
    @(negedge clk);
    rd = 0; wr = 0;
  endtask
  task rdc(input p, input [10:0] s, input [31:0] e, input u);
    cp(0, p, s, 32'h0, u);
    chk32(rdata, e);
  endtask
  // Overflow pulse of one cycle, far side record compared afterwards
  task pulse(input [3:0] o, input [3:0] e);
    @(negedge clk); clr = 1;
    @(negedge clk); clr = 0; ovf = o;
    @(negedge clk); ovf = 0;
    repeat (2) @(negedge clk);
    chk32({28'h0, seen}, {28'h0, e});
  endtask
  initial begin
    #20000;
    err_count = err_count + 1;
    tally_and_finish;
  end
  initial begin
    err_count = 0; tests_run = 0; rst_n = 0; rd = 0; wr = 0; priv = 1; mue = 0;
    clr = 1; crn = 0; crm = 0; op2 = 0; wdata = 0; ovf = 0;
    dimp = `CORR_SIZE_64K; iimp = `CORR_SIZE_32K;
    repeat (8) @(negedge clk);
    rst_n = 1;
    for (k = 0; k < 8; k = k + 1) rdc(1, {eg, k[2:0]}, 32'h0, 0);
    chk1(irq_n & fiq_n & rq_n & !dbg, 1);
    for (k = 0; k < 4; k = k + 1) begin
      cp(1, 1, {eg, k[2:0]}, 32'hffffffff, 0);
      rdc(1, {eg, k[2:0] + 3'h4}, 32'h80000007, 0);
      cp(1, 1, {eg, k[2:0] + 3'h4}, 32'h2, 0);
      rdc(1, {eg, k[2:0]}, 32'h80000005, 0);
      cp(1, 1, {eg, k[2:0]}, 32'h0, 0);
      rdc(1, {eg, k[2:0] + 3'h4}, 32'h80000005, 0);
    end
    for (i = 0; i < 4; i = i + 1) pulse(4'h1 << i, {4{i != 1}});
    rdc(0, {eg, 3'h0}, 32'h0, 1);
    cp(1, 0, {eg, 3'h4}, 32'hffffffff, 1);
    rdc(1, {eg, 3'h0}, 32'h80000005, 0);
    mue = 1;
    rdc(0, {eg, 3'h1}, 32'h80000005, 0);
    for (k = 4; k < 8; k = k + 1) cp(1, 0, {eg, k[2:0]}, 32'hffffffff, 0);
    pulse(4'hf, 4'h0);
    chk1(dsz === dimp && isz === iimp, 1);
    rdc(1, cso, 32'h0, 1);
    cp(1, 0, cso, 32'h33, 1);
    chk1(dsz === dimp && isz === iimp, 1);
    for (k = 0; k < 5; k = k + 1) begin
      cp(1, 1, cso, {24'h0, `CORR_SIZE_4K + k[3:0], `CORR_SIZE_64K - k[3:0]}, 0);
      chk1(dsz === `CORR_SIZE_4K + k[3:0] && isz === `CORR_SIZE_64K - k[3:0], 1);
    end
    rdc(1, {4'hf, 4'h2, 3'h0}, 32'h0, 0);
    tally_and_finish;
  end
endmodule

// ==== src/corr_defs.vh ====
// Purpose: Constants for the counter overflow request routing block
// Assumes: Coprocessor register port selects registers by crn/crm/opc2 codes
// Notes: Included by both design files
`ifndef CORR_DEFS_VH
`define CORR_DEFS_VH

// Register selectors: crm and opc2 within the validation group
`define CORR_CRN_VAL 4'hf
`define CORR_CRM_EN 4'h1
`define CORR_CRM_CSO 4'he
`define CORR_OP2_IRQ_SET 3'h0
`define CORR_OP2_FIQ_SET 3'h1
`define CORR_OP2_RST_SET 3'h2
`define CORR_OP2_DBG_SET 3'h3
`define CORR_OP2_IRQ_CLR 3'h4
`define CORR_OP2_FIQ_CLR 3'h5
`define CORR_OP2_RST_CLR 3'h6
`define CORR_OP2_DBG_CLR 3'h7
`define CORR_OP2_CSO 3'h0

// Enable field positions
`define CORR_BIT_CYC 31
`define CORR_BIT_EV2 2
`define CORR_BIT_EV1 1
`define CORR_BIT_EV0 0

// Cache size override fields
`define CORR_DSIZE_HI 7
`define CORR_DSIZE_LO 4
`define CORR_ISIZE_HI 3
`define CORR_ISIZE_LO 0

// Cache size codes, 4kB to 64kB
`define CORR_SIZE_4K 4'h3
`define CORR_SIZE_8K 4'h4
`define CORR_SIZE_16K 4'h5
`define CORR_SIZE_32K 4'h6
`define CORR_SIZE_64K 4'h7

// Reset values
`define CORR_EN_RESET 4'h0
`define CORR_SIZE_RESET 4'h7

`endif

// ==== src/corr_enable_set.v ====
// Purpose: One request kind: enable state, set/clear and request output
// Assumes: Write strobes are single-cycle and already access-checked
// Notes: Enable order is {cycle, ev2, ev1, ev0}
`timescale 1ns/1ps
`include "corr_defs.vh"

module corr_enable_set (
  input wire clk_in,
  input wire rst_n_in,
  input wire set_wr_in,
  input wire clr_wr_in,
  input wire [31:0] wdata_in,
  input wire [3:0] ovf_in,
  output wire [3:0] en_out,
  output reg req_out
);

  reg [3:0] en_reg; // Shared enable state for set and clear views
  reg [3:0] en_next;
  wire [3:0] wbits; // Written ones gathered from the documented bit positions

  assign wbits = {wdata_in[`CORR_BIT_CYC], wdata_in[`CORR_BIT_EV2],
                  wdata_in[`CORR_BIT_EV1], wdata_in[`CORR_BIT_EV0]};
  assign en_out = en_reg;

  ////////////////////////////////////////////////////////////////////
  // Next enable value
  always @* begin
    en_next = en_reg;
    if (set_wr_in) begin
      en_next = en_next | wbits;
    end
    if (clr_wr_in) begin
      en_next = en_next & ~wbits;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Enable state and registered request
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      en_reg <= `CORR_EN_RESET;
      req_out <= 1'b0;
    end else begin
      en_reg <= en_next;
      // Request on enabled overflow, a one-cycle pulse per overflow
      req_out <= |(en_reg & ovf_in);
    end
  end

endmodule

// ==== src/corr_top.v ====
// Purpose: Route counter overflows to interrupt, fast interrupt, reset, debug
// Assumes: Coprocessor port gives one-cycle read/write strobes with selectors
// Notes: Overflow pulses come from counters on the same clock
//
// Functional notes
// - Cycle bit 31, counters bits 2..0
// - Reset set register reads enables, sets
// - Enabled overflow drives reset request low
// - Debug set register reads enables, sets
// - Enabled overflow drives debug request high
// - Debug registers share same bit layout
// - Interrupt clear register clears, reads enables
// - Fast interrupt clear clears, reads enables
// - Reset clear register clears, reads enables
// - Debug clear register clears, reads enables
// - Privileged always; user needs monitor enable
// - Size override write-only, privileged only
// - Data size 7:4, instruction size 3:0
// - Five sizes, 4kB to 64kB
// - Override replaces reported cache size fields
// - Enabled overflow drives interrupt request low
// - Enabled overflow drives fast interrupt low
`timescale 1ns/1ps
`include "corr_defs.vh"

module corr_top (
  input wire REF_CLK_IN,
  input wire RST_N_IN,
  input wire CP_RD_IN,
  input wire CP_WR_IN,
  input wire [3:0] CP_CRN_IN,
  input wire [3:0] CP_CRM_IN,
  input wire [2:0] CP_OPC2_IN,
  input wire [31:0] CP_WDATA_IN,
  input wire CP_PRIV_IN,
  input wire MONITOR_USER_ACCESS_ENABLE_IN,
  input wire CYCLE_COUNTER_OVF_IN,
  input wire [2:0] EVENT_COUNTER_OVF_IN,
  input wire [3:0] IMPL_DSIZE_IN,
  input wire [3:0] IMPL_ISIZE_IN,
  output reg [31:0] CP_RDATA_OUT,
  output wire CP_UNDEF_OUT,
  output wire OVERFLOW_INTERRUPT_REQUEST_N_OUT,
  output wire OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT,
  output wire OVERFLOW_RESET_REQUEST_N_OUT,
  output wire OVERFLOW_DEBUG_REQUEST_OUT,
  output wire [3:0] CACHE_DSIZE_OUT,
  output wire [3:0] CACHE_ISIZE_OUT
);

  ////////////////////////////////////////////////////////////////////
  // Helpers

  // Spread a 4-bit enable into the 32-bit register layout
  function [31:0] corr_spread;
    input [3:0] en;
    begin
      corr_spread = 32'h0000_0000;
      corr_spread[`CORR_BIT_CYC] = en[3];
      corr_spread[`CORR_BIT_EV2] = en[2];
      corr_spread[`CORR_BIT_EV1] = en[1];
      corr_spread[`CORR_BIT_EV0] = en[0];
    end
  endfunction

  // One of the five supported size codes
  function corr_size_ok;
    input [3:0] code;
    begin
      corr_size_ok = (code == `CORR_SIZE_4K) || (code == `CORR_SIZE_8K) ||
                     (code == `CORR_SIZE_16K) || (code == `CORR_SIZE_32K) ||
                     (code == `CORR_SIZE_64K);
    end
  endfunction

  ////////////////////////////////////////////////////////////////////
  // Decode
  wire [3:0] ovf; // Overflow pulses in enable order
  wire en_grp; // Selector hits an enable register
  wire cso_sel; // Selector hits the size override
  wire user_ok; // Access allowed for enable registers
  wire en_ok;
  wire cso_wr_ok;
  wire [7:0] set_wr; // Per-opc2 write strobes
  wire [3:0] en_irq;
  wire [3:0] en_fiq;
  wire [3:0] en_rst;
  wire [3:0] en_dbg;
  wire req_irq;
  wire req_fiq;
  wire req_rst;
  wire req_dbg;
  reg [3:0] dsize_reg; // Override data size, reported outward
  reg [3:0] isize_reg; // Override instruction size
  reg ovr_reg; // Set once an override has been written
  reg [31:0] rdata_next;

  assign ovf = {CYCLE_COUNTER_OVF_IN, EVENT_COUNTER_OVF_IN};
  assign en_grp = (CP_CRN_IN == `CORR_CRN_VAL) && (CP_CRM_IN == `CORR_CRM_EN);
  assign cso_sel = (CP_CRN_IN == `CORR_CRN_VAL) && (CP_CRM_IN == `CORR_CRM_CSO) &&
                   (CP_OPC2_IN == `CORR_OP2_CSO);
  assign user_ok = CP_PRIV_IN | MONITOR_USER_ACCESS_ENABLE_IN;
  assign en_ok = en_grp & user_ok;
  assign cso_wr_ok = cso_sel & CP_WR_IN & CP_PRIV_IN;

  // Refused accesses are flagged undefined and change nothing
  assign CP_UNDEF_OUT = ((CP_RD_IN | CP_WR_IN) & en_grp & ~user_ok) |
                        (cso_sel & (CP_RD_IN | (CP_WR_IN & ~CP_PRIV_IN)));

  // One strobe per selector value; only the top enable group decodes
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : wr_dec
      // Selector widened to the genvar width so the compare drops no bits
      assign set_wr[g] = CP_WR_IN & en_ok & ({29'h0000_0000, CP_OPC2_IN} == g);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Request kinds, each with shared set/clear state
  // Interrupt set and clear path
  corr_enable_set u_irq (
    .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
    .set_wr_in(set_wr[`CORR_OP2_IRQ_SET]), .clr_wr_in(set_wr[`CORR_OP2_IRQ_CLR]),
    .wdata_in(CP_WDATA_IN), .ovf_in(ovf), .en_out(en_irq), .req_out(req_irq)
  );
  corr_enable_set u_fiq (
    .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
    .set_wr_in(set_wr[`CORR_OP2_FIQ_SET]), .clr_wr_in(set_wr[`CORR_OP2_FIQ_CLR]),
    .wdata_in(CP_WDATA_IN), .ovf_in(ovf), .en_out(en_fiq), .req_out(req_fiq)
  );
  corr_enable_set u_rst (
    .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
    .set_wr_in(set_wr[`CORR_OP2_RST_SET]), .clr_wr_in(set_wr[`CORR_OP2_RST_CLR]),
    .wdata_in(CP_WDATA_IN), .ovf_in(ovf), .en_out(en_rst), .req_out(req_rst)
  );
  corr_enable_set u_dbg (
    .clk_in(REF_CLK_IN), .rst_n_in(RST_N_IN),
    .set_wr_in(set_wr[`CORR_OP2_DBG_SET]), .clr_wr_in(set_wr[`CORR_OP2_DBG_CLR]),
    .wdata_in(CP_WDATA_IN), .ovf_in(ovf), .en_out(en_dbg), .req_out(req_dbg)
  );

  ////////////////////////////////////////////////////////////////////
  // Request outputs
  // Interrupt active low
  assign OVERFLOW_INTERRUPT_REQUEST_N_OUT = ~req_irq;
  assign OVERFLOW_FAST_INTERRUPT_REQUEST_N_OUT = ~req_fiq;
  assign OVERFLOW_RESET_REQUEST_N_OUT = ~req_rst;
  assign OVERFLOW_DEBUG_REQUEST_OUT = req_dbg;

  ////////////////////////////////////////////////////////////////////
  // Read data mux; set and clear views show the same state
  always @* begin
    rdata_next = 32'h0000_0000;
    if (CP_RD_IN && en_ok) begin
      case (CP_OPC2_IN)
        `CORR_OP2_IRQ_SET, `CORR_OP2_IRQ_CLR: begin
          rdata_next = corr_spread(en_irq);
        end
        `CORR_OP2_FIQ_SET, `CORR_OP2_FIQ_CLR: begin
          rdata_next = corr_spread(en_fiq);
        end
        `CORR_OP2_RST_SET, `CORR_OP2_RST_CLR: begin
          rdata_next = corr_spread(en_rst);
        end
        `CORR_OP2_DBG_SET, `CORR_OP2_DBG_CLR: begin
          rdata_next = corr_spread(en_dbg);
        end
        default: begin
          rdata_next = 32'h0000_0000;
        end
      endcase
    end
  end

  // Read data held in a flop, valid the cycle after the read strobe
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      CP_RDATA_OUT <= 32'h0000_0000;
    end else if (CP_RD_IN) begin
      CP_RDATA_OUT <= rdata_next;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Cache size override; illegal codes keep the previous field
  // so a bad write cannot select an unbuilt size
  always @(posedge REF_CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      dsize_reg <= `CORR_SIZE_RESET;
      isize_reg <= `CORR_SIZE_RESET;
      ovr_reg <= 1'b0;
    end else if (cso_wr_ok) begin
      if (corr_size_ok(CP_WDATA_IN[`CORR_DSIZE_HI:`CORR_DSIZE_LO])) begin
        dsize_reg <= CP_WDATA_IN[`CORR_DSIZE_HI:`CORR_DSIZE_LO];
      end
      if (corr_size_ok(CP_WDATA_IN[`CORR_ISIZE_HI:`CORR_ISIZE_LO])) begin
        isize_reg <= CP_WDATA_IN[`CORR_ISIZE_HI:`CORR_ISIZE_LO];
      end
      ovr_reg <= 1'b1;
    end
  end

  assign CACHE_DSIZE_OUT = ovr_reg ? dsize_reg : IMPL_DSIZE_IN;
  assign CACHE_ISIZE_OUT = ovr_reg ? isize_reg : IMPL_ISIZE_IN;

endmodule
